//--- rtl/jtxf_pkg.sv
// shared constants of the transmit transport framer
package jtxf_pkg;
    localparam int SAMPLE_W          = 16;
    localparam int OCTET_W           = 8;
    localparam int SYM_W             = 10;
    localparam int ENC_W             = 11;
    localparam int NUM_CONV          = 2;
    localparam int NUM_LANES         = 2;
    localparam int SAMPLES_PER_FRAME = 1;
    localparam int CTRL_WORDS        = 0;
    localparam int CTRL_BITS         = 0;
    localparam int TAIL_BITS         = 0;
    localparam int HIGH_DENSITY      = 0;
    localparam int FIFO_DEPTH        = 8;
    localparam int K_MAX             = 32;
    localparam int K_W               = 5;
    localparam int IDX_W             = 2;
    localparam logic [IDX_W-1:0] F_LAST_ONE_LANE = 2'h3;
    localparam logic [IDX_W-1:0] F_LAST_TWO_LANE = 2'h1;
    localparam int SCR_W             = 15;
    localparam int SCR_TAP_A         = 13;
    localparam int SCR_TAP_B         = 14;
    localparam logic [SCR_W-1:0] SCR_SEED = 15'h7fff;
    localparam int DEC_W             = 3;
    localparam logic [DEC_W-1:0] DEC_MODE_32 = 3'h1;
    localparam logic [DEC_W-1:0] DEC_MODE_24 = 3'h2;
    localparam logic [DEC_W-1:0] DEC_MODE_16 = 3'h3;
    localparam logic [DEC_W-1:0] DEC_MODE_12 = 3'h4;
    localparam int RATE_W            = 19;
    localparam logic [RATE_W-1:0] RATE_ONE_LANE_MAX_KSPS = 19'h2_5800;
    localparam logic [RATE_W-1:0] RATE_TWO_LANE_MAX_KSPS = 19'h4_11AE;
    localparam int LINE_RATE_MAX_MBPS = 5333;
    localparam logic [4:0] D7_CODE   = 5'h07;
    localparam logic [2:0] X7_CODE   = 3'h7;
    localparam logic [2:0] X3_CODE   = 3'h3;
    localparam logic [5:0] D7_NEG    = 6'h38;
    localparam logic [5:0] D7_POS    = 6'h07;
    localparam logic [3:0] X3_NEG    = 4'hC;
    localparam logic [3:0] X3_POS    = 4'h3;
    localparam logic [3:0] A7_NEG    = 4'h7;
    localparam int BAL6              = 3;
    localparam int BAL4              = 2;
endpackage : jtxf_pkg

//--- rtl/jtxf_fifo.sv
// sample fifo with registered full and empty flags
`timescale 1ns/1ps
module jtxf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic [AW-1:0]    next_rptr;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    assign next_count = count + CW'(push) - CW'(pop);
    assign next_rptr  = pop ? ((rptr == PTR_LAST) ? '0 : rptr + AW'(1)) : rptr;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    // head word from a register; a push into the slot about to be read is forwarded
    always_ff @(posedge mclk_i) begin
        if (push && (wptr == next_rptr)) begin
            out_data_o <= in_data_i;
        end else begin
            out_data_o <= mem[next_rptr];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wptr        <= '0;
            rptr        <= '0;
            count       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wptr <= (wptr == PTR_LAST) ? '0 : wptr + AW'(1);
            end
            rptr        <= next_rptr;
            count       <= next_count;
            in_ready_o  <= (next_count != CNT_FULL);
            out_valid_o <= (next_count != '0);
        end
    end
endmodule : jtxf_fifo

//--- rtl/jtxf_framer.sv
// transmit transport framer: i/q samples to scrambled 8b/10b lane symbols
//
// Notes on behaviour
// - two virtual converters, I and Q, one link
// - one or two lanes; four or two octets/frame
// - one 16-bit sample per converter per frame
// - no control words, no control bits
// - frames per multiframe configurable, up to 32
// - no tail bits, no high density packing
// - high byte first, then low byte
// - optional scrambler, taps fourteen and fifteen
// - each octet encoded to one 10-bit symbol
// - decimation 12 or 16 forces two lanes
// - single lane only up to 153.6 MSPS
// - up to 266.67 MSPS over two lanes
// - receiver configured with identical link parameters
// - I/Q to lane and octet mapping configurable
// - frames delivered as 8-bit octets
// - scrambling off after reset until enabled
`timescale 1ns/1ps
module jtxf_framer
    import jtxf_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    input  wire logic                sample_valid_i,
    input  wire logic [SAMPLE_W-1:0] sample_i_i,
    input  wire logic [SAMPLE_W-1:0] sample_q_i,
    output logic                     sample_ready_o,
    input  wire logic                cfg_two_lane_i,
    input  wire logic                cfg_scramble_i,
    input  wire logic [K_W-1:0]      cfg_k_m1_i,
    input  wire logic                cfg_swap_iq_i,
    input  wire logic [DEC_W-1:0]    cfg_dec_mode_i,
    input  wire logic [RATE_W-1:0]   cfg_rate_ksps_i,
    output logic [OCTET_W-1:0]       lane0_octet_o,
    output logic [OCTET_W-1:0]       lane1_octet_o,
    output logic [SYM_W-1:0]         lane0_sym_o,
    output logic [SYM_W-1:0]         lane1_sym_o,
    output logic [NUM_LANES-1:0]     lane_valid_o,
    output logic                     frame_end_o,
    output logic                     mf_end_o,
    output logic                     two_lane_o,
    output logic                     scramble_on_o,
    output logic                     cfg_error_o
);
    // 5b/6b table, running disparity negative form
    function automatic logic [5:0] code6(input logic [4:0] v);
        logic [5:0] c;
        c = 6'h00;
        unique case (v)
            5'h00: c = 6'b100111;
            5'h01: c = 6'b011101;
            5'h02: c = 6'b101101;
            5'h03: c = 6'b110001;
            5'h04: c = 6'b110101;
            5'h05: c = 6'b101001;
            5'h06: c = 6'b011001;
            5'h07: c = 6'b111000;
            5'h08: c = 6'b111001;
            5'h09: c = 6'b100101;
            5'h0A: c = 6'b010101;
            5'h0B: c = 6'b110100;
            5'h0C: c = 6'b001101;
            5'h0D: c = 6'b101100;
            5'h0E: c = 6'b011100;
            5'h0F: c = 6'b010111;
            5'h10: c = 6'b011011;
            5'h11: c = 6'b100011;
            5'h12: c = 6'b010011;
            5'h13: c = 6'b110010;
            5'h14: c = 6'b001011;
            5'h15: c = 6'b101010;
            5'h16: c = 6'b011010;
            5'h17: c = 6'b111010;
            5'h18: c = 6'b110011;
            5'h19: c = 6'b100110;
            5'h1A: c = 6'b010110;
            5'h1B: c = 6'b110110;
            5'h1C: c = 6'b001110;
            5'h1D: c = 6'b101110;
            5'h1E: c = 6'b011110;
            5'h1F: c = 6'b101011;
        endcase
        return c;
    endfunction : code6

    // 3b/4b table, running disparity negative form, primary x.7
    function automatic logic [3:0] code4(input logic [2:0] v);
        logic [3:0] c;
        c = 4'h0;
        unique case (v)
            3'h0: c = 4'b1011;
            3'h1: c = 4'b1001;
            3'h2: c = 4'b0101;
            3'h3: c = 4'b1100;
            3'h4: c = 4'b1101;
            3'h5: c = 4'b1010;
            3'h6: c = 4'b0110;
            3'h7: c = 4'b1110;
        endcase
        return c;
    endfunction : code4

    // data character encode; result is {new rd, abcdei fghj}
    function automatic logic [ENC_W-1:0] enc8b10b(input logic [OCTET_W-1:0] d,
                                                  input logic               rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic       rd6;
        logic       rdo;
        logic       alt;
        c6  = code6(d[4:0]);
        c4  = code4(d[7:5]);
        rd6 = rd;
        if (d[4:0] == D7_CODE) begin
            c6 = rd ? D7_POS : D7_NEG;
        end else if ($countones(c6) != BAL6) begin
            c6  = rd ? ~c6 : c6;
            rd6 = ~rd;
        end
        // alternate x.7 avoids a run of five equal bits
        alt = (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
              (rd6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E));
        if (d[7:5] == X7_CODE && alt) begin
            c4 = A7_NEG;
        end
        rdo = rd6;
        if (d[7:5] == X3_CODE) begin
            c4 = rd6 ? X3_POS : X3_NEG;
        end else if ($countones(c4) != BAL4) begin
            c4  = rd6 ? ~c4 : c4;
            rdo = ~rd6;
        end
        return {rdo, c6, c4};
    endfunction : enc8b10b

    // self-synchronizing scrambler, msb first; result is {state, octet}
    function automatic logic [SCR_W+OCTET_W-1:0] scramble(input logic [OCTET_W-1:0] d,
                                                         input logic [SCR_W-1:0] st);
        logic [SCR_W-1:0]   s;
        logic [OCTET_W-1:0] o;
        logic               b;
        s = st;
        o = '0;
        for (int i = OCTET_W - 1; i >= 0; i--) begin
            b    = d[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
            o[i] = b;
            s    = {s[SCR_W-2:0], b};
        end
        return {s, o};
    endfunction : scramble

    // container is the sample itself: no tail, padding or control bits
    function automatic logic [OCTET_W-1:0] pick_byte(input logic [SAMPLE_W-1:0] s, input logic lo);
        return lo ? s[OCTET_W-1:0] : s[SAMPLE_W-1:OCTET_W];
    endfunction : pick_byte

    logic                  fifo_valid;
    logic [2*SAMPLE_W-1:0] fifo_data;
    logic                  busy;
    logic [IDX_W-1:0]      oct_idx;
    logic [K_W-1:0]        next_frame;
    logic [K_W-1:0]        cur_frame;
    logic [SAMPLE_W-1:0]   cur_a;
    logic [SAMPLE_W-1:0]   cur_b;
    logic                  two_lane;
    logic                  scr_on;
    logic                  swap_iq;
    logic [K_W-1:0]        k_m1;
    logic [SCR_W-1:0]      scr0;
    logic [SCR_W-1:0]      scr1;
    logic                  rd0;
    logic                  rd1;
    logic                  frame_start;

    // the fifo pops exactly when a frame starts, so no pop is ever lost
    jtxf_fifo #(
        .WIDTH (2 * SAMPLE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (sample_valid_i),
        .in_data_i   ({sample_i_i, sample_q_i}),
        .in_ready_o  (sample_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (frame_start)
    );

    // link parameter checks; the lane override applies at multiframe boundaries, the error flag every cycle
    wire slow_dec   = (cfg_dec_mode_i == DEC_MODE_16) || (cfg_dec_mode_i == DEC_MODE_12);
    wire fast_rate  = cfg_rate_ksps_i > RATE_ONE_LANE_MAX_KSPS;
    wire over_rate  = cfg_rate_ksps_i > RATE_TWO_LANE_MAX_KSPS;
    // a forbidden single lane request is overridden and flagged, never obeyed
    wire must_two   = slow_dec | fast_rate;
    wire want_two   = cfg_two_lane_i | must_two;
    wire bad_cfg    = (~cfg_two_lane_i & must_two) | over_rate;

    wire [IDX_W-1:0] f_last = two_lane ? F_LAST_TWO_LANE : F_LAST_ONE_LANE;
    wire at_last     = busy && (oct_idx == f_last);
    assign frame_start = fifo_valid && (!busy || at_last);
    wire mf_start    = frame_start && (next_frame == '0);
    wire [K_W-1:0] frame_wrap = (next_frame == k_m1) ? '0 : next_frame + K_W'(1);

    // new parameters take effect with the first frame of a multiframe
    wire             use_two  = mf_start ? want_two : two_lane;
    wire             use_swap = mf_start ? cfg_swap_iq_i : swap_iq;
    wire [SAMPLE_W-1:0] in_i  = fifo_data[2*SAMPLE_W-1:SAMPLE_W];
    wire [SAMPLE_W-1:0] in_q  = fifo_data[SAMPLE_W-1:0];

    // octet selection for the frame in flight
    wire                lo_byte   = oct_idx[0];
    wire                second_cv = oct_idx[1];
    wire [SAMPLE_W-1:0] one_src   = second_cv ? cur_b : cur_a;
    wire [OCTET_W-1:0]  raw0      = two_lane ? pick_byte(cur_a, lo_byte) : pick_byte(one_src, lo_byte);
    wire [OCTET_W-1:0]  raw1      = two_lane ? pick_byte(cur_b, lo_byte) : '0;

    wire [SCR_W+OCTET_W-1:0] scr_res0 = scramble(raw0, scr0);
    wire [SCR_W+OCTET_W-1:0] scr_res1 = scramble(raw1, scr1);
    wire [OCTET_W-1:0] oct0 = scr_on ? scr_res0[OCTET_W-1:0] : raw0;
    wire [OCTET_W-1:0] oct1 = scr_on ? scr_res1[OCTET_W-1:0] : raw1;
    wire [ENC_W-1:0]   enc0 = enc8b10b(oct0, rd0);
    wire [ENC_W-1:0]   enc1 = enc8b10b(oct1, rd1);
    wire               emit1 = busy & two_lane;

    // frame sequencing
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            busy       <= 1'b0;
            oct_idx    <= '0;
            next_frame <= '0;
            cur_frame  <= '0;
        end else if (frame_start) begin
            busy       <= 1'b1;
            oct_idx    <= '0;
            cur_frame  <= next_frame;
            next_frame <= mf_start ? ((cfg_k_m1_i == '0) ? '0 : K_W'(1)) : frame_wrap;
        end else if (at_last) begin
            busy       <= 1'b0;
        end else if (busy) begin
            oct_idx    <= oct_idx + IDX_W'(1);
        end
    end

    // sample pair captured at frame start, mapped to octet slots
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cur_a <= '0;
            cur_b <= '0;
        end else if (frame_start) begin
            cur_a <= use_swap ? in_q : in_i;
            cur_b <= use_swap ? in_i : in_q;
        end
    end

    // error flag follows the inputs one cycle later
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cfg_error_o <= 1'b0;
        end else begin
            cfg_error_o <= bad_cfg;
        end
    end

    // link configuration held for a whole multiframe
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            two_lane <= 1'b1;
            scr_on   <= 1'b0;
            swap_iq  <= 1'b0;
            k_m1     <= '0;
        end else if (mf_start) begin
            two_lane <= use_two;
            scr_on   <= cfg_scramble_i;
            swap_iq  <= use_swap;
            k_m1     <= cfg_k_m1_i;
        end
    end

    // lane 0 scrambler and disparity, advanced only on emitted octets
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            scr0 <= SCR_SEED;
            rd0  <= 1'b0;
        end else if (busy) begin
            scr0 <= scr_on ? scr_res0[SCR_W+OCTET_W-1:OCTET_W] : scr0;
            rd0  <= enc0[ENC_W-1];
        end
    end

    // lane 1 state stands still while lane 1 is idle
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            scr1 <= SCR_SEED;
            rd1  <= 1'b0;
        end else if (emit1) begin
            scr1 <= scr_on ? scr_res1[SCR_W+OCTET_W-1:OCTET_W] : scr1;
            rd1  <= enc1[ENC_W-1];
        end
    end

    // framing markers and the link state in effect
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            lane_valid_o  <= '0;
            frame_end_o   <= 1'b0;
            mf_end_o      <= 1'b0;
            two_lane_o    <= 1'b1;
            scramble_on_o <= 1'b0;
        end else begin
            lane_valid_o  <= {emit1, busy};
            frame_end_o   <= at_last;
            mf_end_o      <= at_last && (cur_frame == k_m1);
            two_lane_o    <= two_lane;
            scramble_on_o <= scr_on;
        end
    end

    // lane 0 octet and symbol hold between beats
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            lane0_octet_o <= '0;
            lane0_sym_o   <= '0;
        end else if (busy) begin
            lane0_octet_o <= oct0;
            lane0_sym_o   <= enc0[SYM_W-1:0];
        end
    end

    // lane 1 octet and symbol, idle in single lane mode
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            lane1_octet_o <= '0;
            lane1_sym_o   <= '0;
        end else if (emit1) begin
            lane1_octet_o <= oct1;
            lane1_sym_o   <= enc1[SYM_W-1:0];
        end
    end
endmodule : jtxf_framer

//--- tb/jtxf_framer_asserts.sv
// port checker for the transmit framer
`timescale 1ns/1ps
module jtxf_framer_chk
    import jtxf_pkg::*;
(
    input wire logic                 mclk_i,
    input wire logic                 rst_n_i,
    input wire logic                 sample_ready_o,
    input wire logic                 cfg_two_lane_i,
    input wire logic [K_W-1:0]       cfg_k_m1_i,
    input wire logic [DEC_W-1:0]     cfg_dec_mode_i,
    input wire logic [RATE_W-1:0]    cfg_rate_ksps_i,
    input wire logic [SYM_W-1:0]     lane0_sym_o,
    input wire logic [SYM_W-1:0]     lane1_sym_o,
    input wire logic [NUM_LANES-1:0] lane_valid_o,
    input wire logic                 frame_end_o,
    input wire logic                 mf_end_o,
    input wire logic                 two_lane_o,
    input wire logic                 scramble_on_o,
    input wire logic                 cfg_error_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [K_W-1:0] fcnt;
    logic [1:0]     bcnt;
    wire            fr_done = lane_valid_o[0] && frame_end_o;
    wire            slow_dec = (cfg_dec_mode_i == DEC_MODE_16) || (cfg_dec_mode_i == DEC_MODE_12);
    // counts kept apart from the outputs so a missing marker still shows
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fcnt <= '0;
            bcnt <= '0;
        end else begin
            if (fr_done) fcnt <= (fcnt == cfg_k_m1_i) ? '0 : fcnt + 1'b1;
            if (lane_valid_o[0]) bcnt <= frame_end_o ? '0 : bcnt + 1'b1;
        end
    end
    mf_on_frame_a: assert property (mf_end_o |-> fr_done) else $error("mf end off frame end");
    mf_count_a: assert property (fr_done |-> mf_end_o == (fcnt == cfg_k_m1_i)) else $error("mf length");
    frame_len_a: assert property (fr_done |-> bcnt == (two_lane_o ? 2'd1 : 2'd3)) else $error("frame length");
    one_lane_a: assert property (lane_valid_o[0] && !two_lane_o |-> !lane_valid_o[1]) else $error("lane1 busy");
    two_lane_a: assert property ((|lane_valid_o) && two_lane_o |-> lane_valid_o == 2'b11) else $error("lanes split");
    sym_bal_a: assert property (lane_valid_o[0] |-> $countones(lane0_sym_o) inside {[4:6]}
        && (!lane_valid_o[1] || $countones(lane1_sym_o) inside {[4:6]})) else $error("symbol unbalanced");
    dec_force_a: assert property (!cfg_two_lane_i && slow_dec |=> cfg_error_o) else $error("dec flag");
    rate_flag_a: assert property (cfg_rate_ksps_i > RATE_TWO_LANE_MAX_KSPS || (!cfg_two_lane_i
        && cfg_rate_ksps_i > RATE_ONE_LANE_MAX_KSPS) |=> cfg_error_o) else $error("rate flag");
    cfg_ok_a: assert property (cfg_two_lane_i && cfg_rate_ksps_i <= RATE_TWO_LANE_MAX_KSPS
        |=> !cfg_error_o) else $error("false flag");
    reset_out_a: assert property (disable iff (1'b0) !rst_n_i |=> !scramble_on_o && !sample_ready_o
        && two_lane_o && lane_valid_o == 2'b00) else $error("reset state");
    cover property (fr_done && mf_end_o);
    cover property (lane_valid_o == 2'b11);
    cover property (!sample_ready_o);
    cover property (cfg_error_o);
endmodule : jtxf_framer_chk

bind jtxf_framer jtxf_framer_chk i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sample_ready_o(sample_ready_o),
    .cfg_two_lane_i(cfg_two_lane_i), .cfg_k_m1_i(cfg_k_m1_i), .cfg_dec_mode_i(cfg_dec_mode_i),
    .cfg_rate_ksps_i(cfg_rate_ksps_i), .lane0_sym_o(lane0_sym_o), .lane1_sym_o(lane1_sym_o),
    .lane_valid_o(lane_valid_o), .frame_end_o(frame_end_o), .mf_end_o(mf_end_o), .two_lane_o(two_lane_o),
    .scramble_on_o(scramble_on_o), .cfg_error_o(cfg_error_o));

//--- tb/jtxf_host_rx.sv
// host receiver model: per-lane self-synchronising descrambler
`timescale 1ns/1ps
module jtxf_host_rx
    import jtxf_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 scramble_i,
    input  wire logic [NUM_LANES-1:0] valid_i,
    input  wire logic [OCTET_W-1:0]   oct0_i,
    input  wire logic [OCTET_W-1:0]   oct1_i,
    output logic      [NUM_LANES-1:0] valid_o,
    output logic      [OCTET_W-1:0]   oct0_o,
    output logic      [OCTET_W-1:0]   oct1_o
);
    logic [SCR_W-1:0] h0;
    logic [SCR_W-1:0] h1;
    // history of line bits, newest at bit 0; any seed washes out after 15 bits
    function automatic logic [SCR_W+OCTET_W-1:0] descr(input logic [SCR_W-1:0] hi, input logic [7:0] s);
        logic [SCR_W-1:0] h;
        logic [7:0]       d;
        h = hi;
        for (int b = 7; b >= 0; b--) begin
            d[b] = s[b] ^ h[SCR_TAP_A] ^ h[SCR_TAP_B];
            h = {h[SCR_W-2:0], s[b]};
        end
        return {h, d};
    endfunction : descr
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            h0 <= SCR_SEED;
            h1 <= SCR_SEED;
            valid_o <= '0;
        end else begin
            valid_o <= valid_i;
            if (valid_i[0]) {h0, oct0_o} <= scramble_i ? descr(h0, oct0_i) : {h0, oct0_i};
            if (valid_i[1]) {h1, oct1_o} <= scramble_i ? descr(h1, oct1_i) : {h1, oct1_i};
        end
    end
endmodule : jtxf_host_rx

//--- tb/tb_top.sv
// self-checking bench for the transmit framer
`timescale 1ns/1ps
module tb_top;
    import jtxf_pkg::*;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                s_valid = 1'b0;
    logic [SAMPLE_W-1:0] s_i = '0;
    logic [SAMPLE_W-1:0] s_q = '0;
    logic                c_two = 1'b1;
    logic                c_scr = 1'b0;
    logic [K_W-1:0]      c_k = '0;
    logic                c_swap = 1'b0;
    logic [DEC_W-1:0]    c_dec = DEC_MODE_32;
    logic [RATE_W-1:0]   c_rate = '0;
    wire                 ready, two_on, scr_on, err;
    wire [OCTET_W-1:0]   oct0, oct1, rx0, rx1;
    wire [NUM_LANES-1:0] lv, rv;
    wire [SYM_W-1:0]     sym0;
    logic [SYM_W-1:0]    sym_first;
    logic [OCTET_W-1:0]  q0[$];
    logic [OCTET_W-1:0]  q1[$];
    logic                full_seen;
    int                  n_mismatch = 0;
    int                  num_checks = 0;
    int                  cyc = 0;
    always #5 clk = ~clk;
    jtxf_framer i_dut (.mclk_i(clk), .rst_n_i(rst_n), .sample_valid_i(s_valid), .sample_i_i(s_i),
        .sample_q_i(s_q), .sample_ready_o(ready), .cfg_two_lane_i(c_two), .cfg_scramble_i(c_scr),
        .cfg_k_m1_i(c_k), .cfg_swap_iq_i(c_swap), .cfg_dec_mode_i(c_dec), .cfg_rate_ksps_i(c_rate),
        .lane0_octet_o(oct0), .lane1_octet_o(oct1), .lane0_sym_o(sym0), .lane1_sym_o(), .lane_valid_o(lv),
        .frame_end_o(), .mf_end_o(), .two_lane_o(two_on), .scramble_on_o(scr_on), .cfg_error_o(err));
    jtxf_host_rx i_rx (.mclk_i(clk), .rst_n_i(rst_n), .scramble_i(c_scr), .valid_i(lv), .oct0_i(oct0),
        .oct1_i(oct1), .valid_o(rv), .oct0_o(rx0), .oct1_o(rx1));
    always @(negedge clk) begin
        if (rv[0]) q0.push_back(rx0);
        if (rv[1]) q1.push_back(rx1);
        if (lv[0] && q0.size() == 0) sym_first = sym0;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // octet j of frame k: I hi, I lo, Q hi, Q lo
    function automatic logic [7:0] byt(input int k, input int j);
        logic [31:0] p;
        p = {8'h10 + 8'(k), 8'h80 + 8'(k), 8'h40 + 8'(k), 8'hc0 + 8'(k)};
        return p[31-8*j -: 8];
    endfunction : byt
    task automatic do_reset(input logic two, scr, input logic [K_W-1:0] k, input logic swap,
                            input logic [DEC_W-1:0] dec, input logic [RATE_W-1:0] rate);
        {c_two, c_scr, c_k, c_swap, c_dec, c_rate} = {two, scr, k, swap, dec, rate};
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        q0.delete();
        q1.delete();
        full_seen = 1'b0;
        @(negedge clk);
    endtask : do_reset
    // leaves valid high so back-to-back sends never touch it twice in one step
    task automatic send(input int k);
        int n;
        n = 0;
        s_valid = 1'b1;
        {s_i, s_q} = {byt(k, 0), byt(k, 1), byt(k, 2), byt(k, 3)};
        while (ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n > 0) full_seen = 1'b1;
        @(negedge clk);
    endtask : send
    task automatic drain(input int n0, input int n1);
        int n;
        n = 0;
        s_valid = 1'b0;
        while ((q0.size() < n0 || q1.size() < n1) && n < 400) begin
            @(negedge clk);
            n++;
        end
        repeat (8) @(negedge clk);
        chk(q0.size(), n0);
        chk(q1.size(), n1);
    endtask : drain
    task automatic t_one_lane();
        do_reset(1'b0, 1'b0, 5'h02, 1'b0, DEC_MODE_32, 19'h1_86a0);
        for (int k = 0; k < 12; k++) send(k);
        drain(48, 0);
        for (int k = 0; k < 48; k++) chk(q0[k], byt(k / 4, k % 4));
        chk(full_seen, 1'b1);
        chk(sym_first, 10'h1b4);
        chk({two_on, err}, 2'b00);
    endtask : t_one_lane
    task automatic t_two_lane(input logic swap);
        do_reset(1'b1, 1'b0, 5'h00, swap, DEC_MODE_24, 19'h3_0d40);
        for (int k = 0; k < 6; k++) send(k);
        drain(12, 12);
        for (int k = 0; k < 12; k++) begin
            chk(q0[k], byt(k / 2, k % 2 + (swap ? 2 : 0)));
            chk(q1[k], byt(k / 2, k % 2 + (swap ? 0 : 2)));
        end
        chk({two_on, err}, 2'b10);
    endtask : t_two_lane
    task automatic t_cfg();
        logic              req [5]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        logic [DEC_W-1:0]  dec [5]  = '{DEC_MODE_16, DEC_MODE_12, DEC_MODE_32, DEC_MODE_32, DEC_MODE_24};
        logic [RATE_W-1:0] rate [5] = '{19'h1_86a0, 19'h1_86a0, 19'h2_5801, 19'h4_11af, 19'h2_5800};
        logic [1:0]        want [5] = '{2'b11, 2'b11, 2'b11, 2'b11, 2'b00};
        for (int r = 0; r < 5; r++) begin
            do_reset(req[r], 1'b0, 5'h00, 1'b0, dec[r], rate[r]);
            send(r);
            drain(want[r][1] ? 2 : 4, want[r][1] ? 2 : 0);
            chk({two_on, err}, want[r]);
            chk(q0[0], byt(r, 0));
        end
    endtask : t_cfg
    task automatic t_scramble();
        do_reset(1'b1, 1'b1, 5'h1f, 1'b0, DEC_MODE_32, 19'h1_86a0);
        chk(scr_on, 1'b0);
        for (int k = 0; k < 34; k++) send(k);
        drain(68, 68);
        // first octet pair of each lane depends on the seed, so it is skipped
        for (int k = 2; k < 68; k++) begin
            chk(q0[k], byt(k / 2, k % 2));
            chk(q1[k], byt(k / 2, k % 2 + 2));
        end
        chk(scr_on, 1'b1);
    endtask : t_scramble
    initial begin
        t_one_lane();
        t_two_lane(1'b0);
        t_two_lane(1'b1);
        t_cfg();
        t_scramble();
        final_report();
    end
endmodule : tb_top
